/* hdl/adc_config_regs.vh */
// Register offsets, field positions, reset values and timing counts of the ADC configuration block.
// Summary of operation
// - LED pulse and integration time scale by two to the proximity gain.
// - Sequencer runs any programmed proximity setting without safety checks.
// - Range bit 5 zero gives normal range; one gives gain divided by 14.5.
// - Misc bit 2 selects raw mode (0) or normal proximity mode (1, reset).
// - Raw mode disables LED drives during proximity conversions.
// - Ambient IR select: 0x00 small IR diode, 0x03 large IR diode.
// - Auxiliary select: 0x65 temperature, 0x75 supply, both against ground.
// - Recovery codes 0 to 7 wait 1, 7, 15 up to 511 ADC clocks, times two to the visible gain.
`ifndef ADC_CONFIG_REGS_VH
`define ADC_CONFIG_REGS_VH
`define IDX_PROX_GAIN 10'h00b
`define IDX_PROX_MISC 10'h00c
`define IDX_AMB_IR_SEL 10'h00e
`define IDX_AUX_SEL 10'h00f
`define IDX_VIS_REC 10'h010
`define OFS_PROX_GAIN {`IDX_PROX_GAIN, 2'h0}
`define OFS_PROX_MISC {`IDX_PROX_MISC, 2'h0}
`define OFS_AMB_IR_SEL {`IDX_AMB_IR_SEL, 2'h0}
`define OFS_AUX_SEL {`IDX_AUX_SEL, 2'h0}
`define OFS_VIS_REC {`IDX_VIS_REC, 2'h0}
`define OFS_VIS_GAIN 12'h044
`define OFS_CONTROL 12'h048
`define OFS_STATUS 12'h04c
`define RST_PROX_GAIN 8'h00
`define RST_PROX_MISC 8'h04
`define RST_AMB_IR_SEL 8'h00
`define RST_AUX_SEL 8'h65
`define RST_VIS_REC 8'h70
`define RST_VIS_GAIN 8'h00
`define BIT_PROX_RANGE 5
`define BIT_PROX_MODE 2
`define MSB_REC 6
`define LSB_REC 4
`define AMB_IR_SMALL 8'h00
`define AMB_IR_LARGE 8'h03
`define AUX_TEMP 8'h65
`define AUX_VDD 8'h75
`define ADC_CLK_NS 50
`define CLK_NS 10
`define ADC_DIV 5
`define BASE_PULSE_ADC 8
`define CONV_ADC 16
`define REC_CLKS_0 10'h001
`define REC_CLKS_1 10'h007
`define REC_CLKS_2 10'h00f
`define REC_CLKS_3 10'h01f
`define REC_CLKS_4 10'h03f
`define REC_CLKS_5 10'h07f
`define REC_CLKS_6 10'h0ff
`define REC_CLKS_7 10'h1ff
`define SEL_SMALL_IR 3'h1
`define SEL_LARGE_IR 3'h2
`define SEL_TEMP 3'h3
`define SEL_VDD 3'h4
`define SEL_VISIBLE 3'h5
`define SEL_NONE 3'h0
`endif

/* hdl/adc_config.v */
// APB configuration registers and measurement sequencer for the sensor ADC.
`timescale 1ns/100ps
`include "adc_config_regs.vh"
module adc_config (
  input wire CLK,
  input wire RSTN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  output reg LED_ON,
  output reg ADC_INTEGRATE,
  output reg [2:0] ADC_INPUT,
  output reg HIGH_RANGE
);
  localparam ST_IDLE = 3'd0;
  localparam ST_PROX = 3'd1;
  localparam ST_REC = 3'd2;
  localparam ST_VIS = 3'd3;
  localparam ST_IR = 3'd4;
  localparam ST_AUX = 3'd5;
  // RSTN asserts at once and is released through two flip-flops.
  reg rst_s1_r;
  reg rst_n_r;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end
  reg [7:0] prox_gain_r;
  reg [7:0] prox_misc_r;
  reg [7:0] amb_ir_sel_r;
  reg [7:0] aux_sel_r;
  reg [7:0] vis_rec_r;
  reg [7:0] vis_gain_r;
  reg [3:0] start_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [19:0] cnt_r;
  reg [19:0] cnt_nxt;
  reg [3:0] pend_r;
  reg [9:0] rec_clks;
  wire acc = PSEL & PENABLE;
  wire wr = acc & PWRITE;
  wire mapped = (PADDR == `OFS_PROX_GAIN) || (PADDR == `OFS_PROX_MISC) ||
    (PADDR == `OFS_AMB_IR_SEL) || (PADDR == `OFS_AUX_SEL) || (PADDR == `OFS_VIS_REC) ||
    (PADDR == `OFS_VIS_GAIN) || (PADDR == `OFS_CONTROL) || (PADDR == `OFS_STATUS);
  assign PREADY = 1'b1;
  assign PSLVERR = acc & ~mapped;
  wire [2:0] pgain = prox_gain_r[2:0];
  wire [2:0] vgain = vis_gain_r[2:0];
  wire [2:0] rec = vis_rec_r[`MSB_REC:`LSB_REC];
  wire normal_mode = prox_misc_r[`BIT_PROX_MODE];
  // Pulse and integration widths scale by two to the proximity gain, unguarded.
  wire [19:0] prox_len = (20'd`BASE_PULSE_ADC * 20'd`ADC_DIV) << pgain;
  wire [19:0] rec_len = ({10'h0, rec_clks} * 20'd`ADC_DIV) << vgain;
  wire [19:0] vis_len = (20'd`CONV_ADC * 20'd`ADC_DIV) << vgain;
  wire [19:0] std_len = 20'd`CONV_ADC * 20'd`ADC_DIV;
  // Recovery length in ADC clocks for each code, before the visible gain applies.
  always @* begin
    rec_clks = `REC_CLKS_0;
    case (rec)
      3'h0: rec_clks = `REC_CLKS_0;
      3'h1: rec_clks = `REC_CLKS_1;
      3'h2: rec_clks = `REC_CLKS_2;
      3'h3: rec_clks = `REC_CLKS_3;
      3'h4: rec_clks = `REC_CLKS_4;
      3'h5: rec_clks = `REC_CLKS_5;
      3'h6: rec_clks = `REC_CLKS_6;
      3'h7: rec_clks = `REC_CLKS_7;
      default: rec_clks = `REC_CLKS_0;
    endcase
  end
  always @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prox_gain_r <= `RST_PROX_GAIN;
      prox_misc_r <= `RST_PROX_MISC;
      amb_ir_sel_r <= `RST_AMB_IR_SEL;
      aux_sel_r <= `RST_AUX_SEL;
      vis_rec_r <= `RST_VIS_REC;
      vis_gain_r <= `RST_VIS_GAIN;
      start_r <= 4'h0;
    end else begin
      start_r <= 4'h0;
      if (wr) begin
        if (PADDR == `OFS_PROX_GAIN) begin
          prox_gain_r <= PWDATA[7:0];
        end else if (PADDR == `OFS_PROX_MISC) begin
          prox_misc_r <= PWDATA[7:0];
        end else if (PADDR == `OFS_AMB_IR_SEL) begin
          amb_ir_sel_r <= PWDATA[7:0];
        end else if (PADDR == `OFS_AUX_SEL) begin
          aux_sel_r <= PWDATA[7:0];
        end else if (PADDR == `OFS_VIS_REC) begin
          vis_rec_r <= PWDATA[7:0];
        end else if (PADDR == `OFS_VIS_GAIN) begin
          vis_gain_r <= PWDATA[7:0];
        end else if (PADDR == `OFS_CONTROL) begin
          start_r <= PWDATA[3:0];
        end
      end
    end
  end
  // Read data is captured in the setup phase so it stands through the access phase.
  always @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= 32'h0;
      if (PADDR == `OFS_PROX_GAIN) begin
        PRDATA <= {24'h0, prox_gain_r};
      end else if (PADDR == `OFS_PROX_MISC) begin
        PRDATA <= {24'h0, prox_misc_r};
      end else if (PADDR == `OFS_AMB_IR_SEL) begin
        PRDATA <= {24'h0, amb_ir_sel_r};
      end else if (PADDR == `OFS_AUX_SEL) begin
        PRDATA <= {24'h0, aux_sel_r};
      end else if (PADDR == `OFS_VIS_REC) begin
        PRDATA <= {24'h0, vis_rec_r};
      end else if (PADDR == `OFS_VIS_GAIN) begin
        PRDATA <= {24'h0, vis_gain_r};
      end else if (PADDR == `OFS_STATUS) begin
        PRDATA <= {25'h0, pend_r, state_r};
      end
    end
  end
  // Launch priority is proximity, visible, ambient IR, then auxiliary.
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (state_r != ST_IDLE) begin
      if (cnt_r > 20'h1) begin
        cnt_nxt = cnt_r - 20'h1;
      end else begin
        state_nxt = ST_IDLE;
        cnt_nxt = 20'h0;
        if (state_r == ST_REC) begin
          state_nxt = ST_VIS;
          cnt_nxt = vis_len;
        end
      end
    end else if (pend_r[0]) begin
      state_nxt = ST_PROX;
      cnt_nxt = prox_len;
    end else if (pend_r[1]) begin
      state_nxt = ST_REC;
      cnt_nxt = rec_len;
    end else if (pend_r[2]) begin
      state_nxt = ST_IR;
      cnt_nxt = std_len;
    end else if (pend_r[3]) begin
      state_nxt = ST_AUX;
      cnt_nxt = std_len;
    end
  end
  always @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      cnt_r <= 20'h0;
      pend_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      // A new start request wins over the launch that clears its pending bit.
      if (state_r == ST_IDLE) begin
        if (pend_r[0]) begin
          pend_r <= (pend_r & 4'he) | start_r;
        end else if (pend_r[1]) begin
          pend_r <= (pend_r & 4'hd) | start_r;
        end else if (pend_r[2]) begin
          pend_r <= (pend_r & 4'hb) | start_r;
        end else begin
          pend_r <= (pend_r & 4'h7) | start_r;
        end
      end else begin
        pend_r <= pend_r | start_r;
      end
    end
  end
  always @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      LED_ON <= 1'b0;
      ADC_INTEGRATE <= 1'b0;
      ADC_INPUT <= `SEL_NONE;
      HIGH_RANGE <= 1'b0;
    end else begin
      // Only normal proximity mode drives the LED; raw mode measures the diode alone.
      LED_ON <= (state_nxt == ST_PROX) && normal_mode;
      ADC_INTEGRATE <= (state_nxt == ST_PROX) || (state_nxt == ST_VIS) ||
        (state_nxt == ST_IR) || (state_nxt == ST_AUX);
      HIGH_RANGE <= (state_nxt == ST_PROX) && prox_misc_r[`BIT_PROX_RANGE];
      ADC_INPUT <= `SEL_NONE;
      if (state_nxt == ST_PROX) begin
        ADC_INPUT <= `SEL_LARGE_IR;
      end else if (state_nxt == ST_VIS) begin
        ADC_INPUT <= `SEL_VISIBLE;
      end else if (state_nxt == ST_IR) begin
        if (amb_ir_sel_r == `AMB_IR_LARGE) begin
          ADC_INPUT <= `SEL_LARGE_IR;
        end else if (amb_ir_sel_r == `AMB_IR_SMALL) begin
          ADC_INPUT <= `SEL_SMALL_IR;
        end
      end else if (state_nxt == ST_AUX) begin
        if (aux_sel_r == `AUX_TEMP) begin
          ADC_INPUT <= `SEL_TEMP;
        end else if (aux_sel_r == `AUX_VDD) begin
          ADC_INPUT <= `SEL_VDD;
        end
      end
    end
  end
endmodule // adc_config

/* sim/adc_config_props.sv */
// Port checks for the ADC configuration block.
`timescale 1ns/100ps
module adc_config_props (
  input wire CLK,
  input wire RSTN,
  input wire PSEL,
  input wire PENABLE,
  input wire PSLVERR,
  input wire LED_ON,
  input wire ADC_INTEGRATE,
  input wire [2:0] ADC_INPUT,
  input wire HIGH_RANGE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_led; LED_ON [*8]; endsequence
  sequence s_conv; ADC_INTEGRATE [*8]; endsequence
  property p_led_in; LED_ON |-> ADC_INTEGRATE && ADC_INPUT == 3'h2; endproperty
  a_led_in: assert property (p_led_in) else $error("led");
  property p_range; HIGH_RANGE |-> ADC_INTEGRATE && ADC_INPUT == 3'h2; endproperty
  a_range: assert property (p_range) else $error("range");
  property p_led_end; $fell(LED_ON) |-> !ADC_INTEGRATE; endproperty
  a_led_end: assert property (p_led_end) else $error("led end");
  property p_led_min; $rose(LED_ON) |-> s_led; endproperty
  a_led_min: assert property (p_led_min) else $error("led short");
  property p_conv_min; $rose(ADC_INTEGRATE) |-> s_conv; endproperty
  a_conv_min: assert property (p_conv_min) else $error("conv short");
  property p_rec; $rose(ADC_INTEGRATE) && ADC_INPUT == 3'h5 |-> !$past(ADC_INTEGRATE, 4); endproperty
  a_rec: assert property (p_rec) else $error("recovery");
  property p_idle; !ADC_INTEGRATE |-> ADC_INPUT == 3'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle input");
  property p_err; PSLVERR |-> PSEL && PENABLE; endproperty
  a_err: assert property (p_err) else $error("slave error");
endmodule // adc_config_props
bind adc_config adc_config_props u_props (.CLK, .RSTN, .PSEL, .PENABLE, .PSLVERR, .LED_ON,
  .ADC_INTEGRATE, .ADC_INPUT, .HIGH_RANGE);

/* sim/apb_host.sv */
// Host model that drives the register bus.
`timescale 1ns/100ps
module apb_host (
  input wire CLK,
  input wire PREADY,
  input wire [31:0] PRDATA,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [11:0] PADDR,
  output logic [31:0] PWDATA
);
  initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    q = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
endmodule // apb_host

/* sim/tb.sv */
// Self-checking bench for the ADC configuration block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  wire PSEL, PENABLE, PWRITE, PREADY, PSLVERR, LED_ON, ADC_INTEGRATE, HIGH_RANGE;
  wire [11:0] PADDR;
  wire [31:0] PWDATA, PRDATA;
  wire [2:0] ADC_INPUT;
  int errors = 0;
  int check_count = 0;
  int len, gap, g0;
  logic led, hr;
  logic [2:0] inp;
  logic [31:0] q;
  logic err_seen;
  always #5 CLK = ~CLK;
  always @(posedge CLK) if (PSEL && PENABLE) err_seen <= PSLVERR;
  apb_host u_apb_host (.CLK, .PREADY, .PRDATA, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA);
  adc_config u_adc_config (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .LED_ON, .ADC_INTEGRATE, .ADC_INPUT, .HIGH_RANGE);
  task automatic tally_and_finish;
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_apb_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    u_apb_host.xfer(1'b0, a, 32'h0, q);
    `CHK("rdata", e, q)
  endtask
  task automatic meas(input logic [3:0] b);
    wr(12'h048, {28'h0, b});
    gap = 0;
    len = 0;
    while (ADC_INTEGRATE !== 1'b1 && gap < 9000) @(posedge CLK) #1 gap++;
    {led, hr, inp} = {LED_ON, HIGH_RANGE, ADC_INPUT};
    while (ADC_INTEGRATE === 1'b1 && len < 9000) @(posedge CLK) #1 len++;
  endtask
  task automatic t_prox(input logic [7:0] g, m, input logic el, eh);
    wr(12'h02c, {24'h0, g});
    wr(12'h030, {24'h0, m});
    meas(4'h1);
    `CHK("plen", 40 << g[2:0], len)
    `CHK("led", el, led)
    `CHK("range", eh, hr)
    `CHK("pin", 3'h2, inp)
  endtask
  task automatic t_mux(input logic [11:0] a, input logic [7:0] c, input logic [3:0] b,
      input logic [2:0] e);
    wr(a, {24'h0, c});
    meas(b);
    `CHK("mux", e, inp)
  endtask
  task automatic t_vis;
    wr(12'h040, 32'h00);
    meas(4'h2);
    g0 = gap;
    `CHK("vlen", 80, len)
    `CHK("vin", 3'h5, inp)
    wr(12'h040, 32'h10);
    meas(4'h2);
    `CHK("vrec", 30, gap - g0)
    wr(12'h044, 32'h01);
    wr(12'h040, 32'h60);
    meas(4'h2);
    `CHK("vlen2", 160, len)
    `CHK("vrec2", 2545, gap - g0)
  endtask
  task automatic t_bus;
    wr(12'h02c, 32'hffffff05);
    rd(12'h02c, 32'h05);
    #1 `CHK("slverr", 1'b0, err_seen)
    rd(12'hffc, 32'h0);
    #1 `CHK("slverr", 1'b1, err_seen)
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(12'h02c, 32'h00);
    rd(12'h030, 32'h04);
    rd(12'h038, 32'h00);
    rd(12'h03c, 32'h65);
    rd(12'h040, 32'h70);
    t_bus;
    t_prox(8'h00, 8'h04, 1'b1, 1'b0);
    t_prox(8'h05, 8'h24, 1'b1, 1'b1);
    t_prox(8'h02, 8'h20, 1'b0, 1'b1);
    t_prox(8'h01, 8'h00, 1'b0, 1'b0);
    t_mux(12'h038, 8'h00, 4'h4, 3'h1);
    t_mux(12'h038, 8'h03, 4'h4, 3'h2);
    t_mux(12'h03c, 8'h65, 4'h8, 3'h3);
    t_mux(12'h03c, 8'h75, 4'h8, 3'h4);
    t_vis;
    tally_and_finish;
  end
  initial begin
    #500000;
    errors++;
    tally_and_finish;
  end
endmodule // tb
